// File: hw/fcs_flash_command_sequencer.sv
/*
  Command sequencer of one flash array: decodes host byte writes, starts and
  stops the cell core, and answers host reads with array data or status.
  Assumes host bus strobes are one-cycle pulses synchronous to i_sys_clk, that
  the cell core answers o_core_start with one i_core_done pulse, and that one
  sector select is active for every host access.
*/
// Contract
// - unlock AA, 55 then 20h enters bypass mode
// - in bypass, A0h then address and data programs one byte
// - 90h then 00h leaves bypass and returns to read array
// - in bypass every other command is ignored
// - bulk erase is six writes; any wrong byte aborts to read array
// - bulk erase on any sector select erases the whole array
// - bulk erase status shows error, toggle and polling flags
// - during bulk erase every other command is rejected
// - sector erase is six writes; 30h appends sectors within 80 us
// - timeout flag is zero while appending allowed, one after 80 us
// - running sector erase accepts only reset and suspend
// - B0h suspends sector erase, honoured in the append window and while erasing
// - suspend halts within 15 us; toggle flag shows when halted
// - while suspended, erased sector reads invalid, others valid
// - while suspended, no programming; only resume and reset
// - 30h resumes the suspended sector erase
// - reset command returns to read array; needed after errors
// - reset ignored in program or bulk; aborts sector erase in 25 us
// - module reset aborts any operation, read array within 25 us
// - program or erase of protected sector ignored; reads still allowed
// - toggle flag inverts on each read while busy
// - polling flag reads zero until an erase completes
`timescale 1ns/1ps
`include "fcs_defs.svh"

module fcs_flash_command_sequencer #(
  parameter int              AW           = 16,
  parameter int              NSEC         = 12,
  parameter int              TW           = 16,
  parameter logic [AW-1:0]   UNLOCK_ADDR1 = `FCS_UNLOCK_ADDR1,
  parameter logic [AW-1:0]   UNLOCK_ADDR2 = `FCS_UNLOCK_ADDR2,
  parameter int              WIN_CYC      = `FCS_WIN_CYC,
  parameter int              SUSP_CYC     = `FCS_SUSP_CYC,
  parameter int              ABORT_CYC    = `FCS_ABORT_CYC
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_srst,
  input  wire logic            i_mod_reset,
  input  wire logic            i_bus_wr,
  input  wire logic            i_bus_rd,
  input  wire logic [AW-1:0]   i_bus_addr,
  input  wire logic [7:0]      i_bus_wdata,
  input  wire logic [NSEC-1:0] i_sector_sel,
  input  wire logic [NSEC-1:0] i_sector_prot,
  input  wire logic [7:0]      i_array_rdata,
  input  wire logic            i_core_done,
  input  wire logic            i_core_fail,
  output logic [7:0]           o_bus_rdata,
  output logic                 o_bus_rvalid,
  output logic                 o_rd_invalid,
  output logic                 o_core_start,
  output fcs_pkg::fcs_op_t     o_core_op,
  output logic [AW-1:0]        o_core_addr,
  output logic [7:0]           o_core_data,
  output logic [NSEC-1:0]      o_core_mask,
  output logic                 o_core_suspend,
  output logic                 o_core_abort,
  output logic                 o_ready,
  output logic                 o_bypass
);

  // ==========================================================
  // helpers
  function automatic logic fcs_hit(input logic [NSEC-1:0] a, input logic [NSEC-1:0] b);
    fcs_hit = |(a & b);
  endfunction : fcs_hit

  function automatic logic fcs_busy(input fcs_pkg::fcs_state_t s);
    fcs_busy = (s == fcs_pkg::ST_PROG) || (s == fcs_pkg::ST_BULK) || (s == fcs_pkg::ST_SWIN) ||
               (s == fcs_pkg::ST_SECT) || (s == fcs_pkg::ST_SWAIT) || (s == fcs_pkg::ST_ERR);
  endfunction : fcs_busy

  // ==========================================================
  // state
  fcs_pkg::fcs_state_t state_q, state_d;
  fcs_pkg::fcs_op_t    op_q, op_d;
  logic [TW-1:0]       tmr_q, tmr_d;
  logic [NSEC-1:0]     mask_q, mask_d;
  logic [AW-1:0]       addr_q, addr_d;
  logic [7:0]          data_q, data_d;
  logic                byp_q, byp_d;
  logic                err_q, err_d;
  logic                pol_q, pol_d;
  logic                tog_q, tog_d;
  logic                start_q, start_d;
  logic                abort_q, abort_d;
  logic [7:0]          rdata_q, rdata_d;
  logic                rvalid_q, rvalid_d;
  logic                inval_q, inval_d;

  logic                wr_ok;
  logic                prot_hit;
  logic [7:0]          cmd;
  logic [7:0]          status;

  assign wr_ok    = i_bus_wr && (|i_sector_sel);
  assign prot_hit = fcs_hit(i_sector_sel, i_sector_prot);
  assign cmd      = i_bus_wdata;

  // status byte; undefined bits read zero
  always_comb begin
    status                 = 8'h00;
    status[`FCS_ST_POLL]   = (state_q == fcs_pkg::ST_PROG) ? pol_q : 1'b0;
    status[`FCS_ST_TOGGLE] = tog_q;
    status[`FCS_ST_ERROR]  = err_q;
    status[`FCS_ST_TIMEOUT] = (state_q == fcs_pkg::ST_SECT) || (state_q == fcs_pkg::ST_SWAIT) ||
                              (state_q == fcs_pkg::ST_SUSP);
  end

  // ==========================================================
  // next state
  always_comb begin
    state_d  = state_q;
    op_d     = op_q;
    tmr_d    = (tmr_q != '0) ? tmr_q - TW'(1) : tmr_q;
    mask_d   = mask_q;
    addr_d   = addr_q;
    data_d   = data_q;
    byp_d    = byp_q;
    err_d    = err_q;
    pol_d    = pol_q;
    tog_d    = tog_q;
    start_d  = 1'b0;
    abort_d  = 1'b0;
    rdata_d  = rdata_q;
    rvalid_d = i_bus_rd;
    inval_d  = 1'b0;

    // host reads
    if (i_bus_rd) begin
      if (fcs_busy(state_q)) begin
        rdata_d = status;
        tog_d   = ~tog_q;
      end else if (state_q == fcs_pkg::ST_SUSP && fcs_hit(i_sector_sel, mask_q)) begin
        rdata_d = 8'hFF;
        inval_d = 1'b1;
      end else begin
        rdata_d = i_array_rdata;
      end
    end

    case (state_q)
      fcs_pkg::ST_READ: begin
        if (wr_ok && cmd == `FCS_CMD_UNLOCK1 && i_bus_addr == UNLOCK_ADDR1) begin
          state_d = fcs_pkg::ST_UNL1;
        end
      end
      fcs_pkg::ST_UNL1: begin
        if (wr_ok) begin
          state_d = (cmd == `FCS_CMD_UNLOCK2 && i_bus_addr == UNLOCK_ADDR2) ? fcs_pkg::ST_UNL2 : fcs_pkg::ST_READ;
        end
      end
      fcs_pkg::ST_UNL2: begin
        if (wr_ok) begin
          case (cmd)
            `FCS_CMD_BYPASS:      begin state_d = fcs_pkg::ST_BYP;  byp_d = 1'b1; end
            `FCS_CMD_PROGRAM:     state_d = fcs_pkg::ST_PSET;
            `FCS_CMD_ERASE_SETUP: state_d = fcs_pkg::ST_ERS0;
            default:              state_d = fcs_pkg::ST_READ;
          endcase
        end
      end
      fcs_pkg::ST_PSET: begin
        if (wr_ok) begin
          if (prot_hit) begin
            state_d = byp_q ? fcs_pkg::ST_BYP : fcs_pkg::ST_READ;
          end else begin
            state_d = fcs_pkg::ST_PROG;
            op_d    = fcs_pkg::OP_PROG;
            addr_d  = i_bus_addr;
            data_d  = i_bus_wdata;
            pol_d   = ~i_bus_wdata[7];
            err_d   = 1'b0;
            start_d = 1'b1;
          end
        end
      end
      fcs_pkg::ST_PROG: begin
        // reset command and new sequences are ignored here
        if (i_core_done) begin
          err_d   = i_core_fail;
          pol_d   = data_q[7];
          state_d = i_core_fail ? fcs_pkg::ST_ERR : (byp_q ? fcs_pkg::ST_BYP : fcs_pkg::ST_READ);
        end
      end
      fcs_pkg::ST_BYP: begin
        if (wr_ok) begin
          if (cmd == `FCS_CMD_PROGRAM) begin
            state_d = fcs_pkg::ST_PSET;
          end else if (cmd == `FCS_CMD_BYP_EXIT1) begin
            state_d = fcs_pkg::ST_BYPX;
          end
          // anything else leaves the mode untouched
        end
      end
      fcs_pkg::ST_BYPX: begin
        if (wr_ok) begin
          if (cmd == `FCS_CMD_BYP_EXIT2) begin
            state_d = fcs_pkg::ST_READ;
            byp_d   = 1'b0;
          end else begin
            state_d = fcs_pkg::ST_BYP;
          end
        end
      end
      fcs_pkg::ST_ERS0: begin
        if (wr_ok) begin
          state_d = (cmd == `FCS_CMD_UNLOCK1 && i_bus_addr == UNLOCK_ADDR1) ? fcs_pkg::ST_ERS1 : fcs_pkg::ST_READ;
        end
      end
      fcs_pkg::ST_ERS1: begin
        if (wr_ok) begin
          state_d = (cmd == `FCS_CMD_UNLOCK2 && i_bus_addr == UNLOCK_ADDR2) ? fcs_pkg::ST_ERS2 : fcs_pkg::ST_READ;
        end
      end
      fcs_pkg::ST_ERS2: begin
        if (wr_ok) begin
          state_d = fcs_pkg::ST_READ;
          err_d   = 1'b0;
          addr_d  = i_bus_addr;
          if (cmd == `FCS_CMD_BULK && !(|i_sector_prot)) begin
            // a protected sector anywhere blocks the whole-array erase
            state_d = fcs_pkg::ST_BULK;
            op_d    = fcs_pkg::OP_BULK;
            mask_d  = '1;
            start_d = 1'b1;
          end else if (cmd == `FCS_CMD_SECTOR && !prot_hit) begin
            state_d = fcs_pkg::ST_SWIN;
            op_d    = fcs_pkg::OP_SECTOR;
            mask_d  = i_sector_sel;
            tmr_d   = TW'(WIN_CYC);
          end
        end
      end
      fcs_pkg::ST_BULK: begin
        if (i_core_done) begin
          err_d   = i_core_fail;
          state_d = i_core_fail ? fcs_pkg::ST_ERR : fcs_pkg::ST_READ;
        end
      end
      fcs_pkg::ST_SWIN: begin
        if (wr_ok && cmd == `FCS_CMD_RESET) begin
          state_d = fcs_pkg::ST_READ;
          mask_d  = '0;
        end else if (wr_ok && cmd == `FCS_CMD_SECTOR) begin
          if (!prot_hit) begin
            mask_d = mask_q | i_sector_sel;
            tmr_d  = TW'(WIN_CYC);
          end
        end else if (wr_ok && cmd == `FCS_CMD_SUSPEND) begin
          // start the erase at once so that it can be halted like a running one
          start_d = 1'b1;
          state_d = fcs_pkg::ST_SWAIT;
          tmr_d   = TW'(SUSP_CYC);
        end else if (tmr_q == '0) begin
          start_d = 1'b1;
          state_d = fcs_pkg::ST_SECT;
        end
      end
      fcs_pkg::ST_SECT: begin
        if (i_core_done) begin
          err_d   = i_core_fail;
          state_d = i_core_fail ? fcs_pkg::ST_ERR : fcs_pkg::ST_READ;
        end else if (wr_ok && cmd == `FCS_CMD_SUSPEND) begin
          state_d = fcs_pkg::ST_SWAIT;
          tmr_d   = TW'(SUSP_CYC);
        end else if (wr_ok && cmd == `FCS_CMD_RESET) begin
          state_d = fcs_pkg::ST_ABORT;
          abort_d = 1'b1;
          tmr_d   = TW'(ABORT_CYC);
        end
      end
      fcs_pkg::ST_SWAIT: begin
        if (tmr_q == '0) begin
          state_d = fcs_pkg::ST_SUSP;
        end
      end
      fcs_pkg::ST_SUSP: begin
        if (wr_ok && cmd == `FCS_CMD_RESUME) begin
          state_d = fcs_pkg::ST_SECT;
        end else if (wr_ok && cmd == `FCS_CMD_RESET) begin
          state_d = fcs_pkg::ST_ABORT;
          abort_d = 1'b1;
          tmr_d   = TW'(ABORT_CYC);
        end
      end
      fcs_pkg::ST_ABORT: begin
        if (tmr_q == '0) begin
          state_d = fcs_pkg::ST_READ;
          mask_d  = '0;
        end
      end
      fcs_pkg::ST_ERR: begin
        if (wr_ok && cmd == `FCS_CMD_RESET) begin
          state_d = fcs_pkg::ST_READ;
          err_d   = 1'b0;
          byp_d   = 1'b0;
        end
      end
      default: begin
        state_d = fcs_pkg::ST_READ;
      end
    endcase

    // module reset overrides everything and holds the abort while asserted
    if (i_mod_reset) begin
      state_d = fcs_pkg::ST_ABORT;
      abort_d = 1'b1;
      start_d = 1'b0;
      byp_d   = 1'b0;
      err_d   = 1'b0;
      tmr_d   = TW'(ABORT_CYC);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_q  <= fcs_pkg::ST_READ;
      op_q     <= fcs_pkg::OP_NONE;
      tmr_q    <= '0;
      mask_q   <= '0;
      addr_q   <= '0;
      data_q   <= 8'h00;
      byp_q    <= 1'b0;
      err_q    <= 1'b0;
      pol_q    <= 1'b0;
      tog_q    <= 1'b0;
      start_q  <= 1'b0;
      abort_q  <= 1'b0;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      inval_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      op_q     <= op_d;
      tmr_q    <= tmr_d;
      mask_q   <= mask_d;
      addr_q   <= addr_d;
      data_q   <= data_d;
      byp_q    <= byp_d;
      err_q    <= err_d;
      pol_q    <= pol_d;
      tog_q    <= tog_d;
      start_q  <= start_d;
      abort_q  <= abort_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      inval_q  <= inval_d;
    end
  end

  assign o_bus_rdata    = rdata_q;
  assign o_bus_rvalid   = rvalid_q;
  assign o_rd_invalid   = inval_q;
  assign o_core_start   = start_q;
  assign o_core_op      = op_q;
  assign o_core_addr    = addr_q;
  assign o_core_data    = data_q;
  assign o_core_mask    = mask_q;
  assign o_core_suspend = (state_q == fcs_pkg::ST_SWAIT) || (state_q == fcs_pkg::ST_SUSP);
  assign o_core_abort   = abort_q;
  assign o_ready        = !fcs_busy(state_q) && (state_q != fcs_pkg::ST_ABORT);
  assign o_bypass       = byp_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  chk_bypass_entry: assert property ($rose(o_bypass) |-> $past(state_q) == fcs_pkg::ST_UNL2 &&
    $past(cmd) == `FCS_CMD_BYPASS && $past(wr_ok)) else $error("bypass entered without sequence");
  chk_bypass_prog: assert property (state_q == fcs_pkg::ST_PSET && byp_q && wr_ok && !prot_hit && !i_mod_reset
    |=> o_core_start && o_core_op == fcs_pkg::OP_PROG && o_core_addr == $past(i_bus_addr)) else $error("bypass program lost");
  chk_bypass_exit: assert property (state_q == fcs_pkg::ST_BYPX && wr_ok && cmd == `FCS_CMD_BYP_EXIT2 && !i_mod_reset
    |=> state_q == fcs_pkg::ST_READ && !o_bypass) else $error("bypass exit failed");
  chk_bypass_ignore: assert property (state_q == fcs_pkg::ST_BYP && i_bus_wr && cmd != `FCS_CMD_PROGRAM &&
    cmd != `FCS_CMD_BYP_EXIT1 && !i_mod_reset |=> state_q == fcs_pkg::ST_BYP && !o_core_start) else $error("bypass took command");
  chk_bulk_abort: assert property (state_q == fcs_pkg::ST_ERS1 && wr_ok && cmd != `FCS_CMD_UNLOCK2 && !i_mod_reset
    |=> state_q == fcs_pkg::ST_READ) else $error("bad erase byte not aborted");
  chk_bulk_mask: assert property (o_core_start && o_core_op == fcs_pkg::OP_BULK |-> &o_core_mask)
    else $error("bulk erase not whole array");
  chk_bulk_reject: assert property (state_q == fcs_pkg::ST_BULK && !i_core_done && !i_mod_reset
    |=> state_q == fcs_pkg::ST_BULK && !o_core_abort) else $error("bulk erase interrupted");
  chk_timeout_flag: assert property (o_bus_rvalid && $past(state_q) == fcs_pkg::ST_SWIN
    |-> !o_bus_rdata[`FCS_ST_TIMEOUT]) else $error("timeout flag set in window");
  chk_sect_reset: assert property (state_q == fcs_pkg::ST_SECT && wr_ok && cmd == `FCS_CMD_RESET && !i_core_done
    |=> o_core_abort && state_q == fcs_pkg::ST_ABORT) else $error("reset did not abort sector erase");
  chk_prog_reset: assert property (state_q == fcs_pkg::ST_PROG && i_bus_wr && !i_core_done && !i_mod_reset
    |=> state_q == fcs_pkg::ST_PROG) else $error("program interrupted");
  chk_mod_reset: assert property (i_mod_reset |=> o_core_abort && state_q == fcs_pkg::ST_ABORT && !o_bypass)
    else $error("module reset ignored");
  chk_prot_ignore: assert property (state_q == fcs_pkg::ST_PSET && wr_ok && prot_hit |=> !o_core_start)
    else $error("protected sector programmed");
  chk_toggle_flip: assert property (i_bus_rd && fcs_busy(state_q) |=> tog_q != $past(tog_q))
    else $error("toggle flag did not invert");
  chk_poll_erase: assert property (o_bus_rvalid && $past(state_q) == fcs_pkg::ST_BULK |-> !o_bus_rdata[`FCS_ST_POLL])
    else $error("polling flag high during erase");
  chk_susp_invalid: assert property (state_q == fcs_pkg::ST_SUSP && i_bus_rd && fcs_hit(i_sector_sel, mask_q)
    |=> o_rd_invalid) else $error("erased sector read as valid");
  chk_susp_hold: assert property (state_q == fcs_pkg::ST_SUSP && i_bus_wr && cmd != `FCS_CMD_RESUME &&
    cmd != `FCS_CMD_RESET && !i_mod_reset |=> state_q == fcs_pkg::ST_SUSP && !o_core_start) else $error("suspend left");
  chk_resume: assert property (state_q == fcs_pkg::ST_SUSP && wr_ok && cmd == `FCS_CMD_RESUME && !i_mod_reset
    |=> state_q == fcs_pkg::ST_SECT && !o_core_suspend) else $error("resume failed");

  cov_bypass_prog: cover property (o_bypass && o_core_start && o_core_op == fcs_pkg::OP_PROG);
  cov_bulk_done: cover property (state_q == fcs_pkg::ST_BULK ##1 state_q == fcs_pkg::ST_READ);
  cov_suspend: cover property (state_q == fcs_pkg::ST_SWAIT ##1 state_q == fcs_pkg::ST_SUSP);
  cov_append: cover property (state_q == fcs_pkg::ST_SWIN && wr_ok && cmd == `FCS_CMD_SECTOR);

endmodule : fcs_flash_command_sequencer

// File: hw/fcs_defs.svh
/*
  Constants of the flash command sequencer: command bytes, status bit
  positions, default unlock addresses and timing counts.
  Assumes a 200 MHz system clock; included by bare name.
*/
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// ==========================================================
// command bytes
`define FCS_CMD_UNLOCK1      8'hAA
`define FCS_CMD_UNLOCK2      8'h55
`define FCS_CMD_BYPASS       8'h20
`define FCS_CMD_PROGRAM      8'hA0
`define FCS_CMD_BYP_EXIT1    8'h90
`define FCS_CMD_BYP_EXIT2    8'h00
`define FCS_CMD_ERASE_SETUP  8'h80
`define FCS_CMD_BULK         8'h10
`define FCS_CMD_SECTOR       8'h30
`define FCS_CMD_SUSPEND      8'hB0
`define FCS_CMD_RESUME       8'h30
`define FCS_CMD_RESET        8'hF0

// ==========================================================
// default unlock addresses
`define FCS_UNLOCK_ADDR1     16'h0555
`define FCS_UNLOCK_ADDR2     16'h0AAA

// ==========================================================
// status byte bit positions
`define FCS_ST_POLL          7
`define FCS_ST_TOGGLE        6
`define FCS_ST_ERROR         5
`define FCS_ST_TIMEOUT       3

// ==========================================================
// timing
`define FCS_CLK_PERIOD_NS    5
`define FCS_WIN_TIME_US      80
`define FCS_SUSP_TIME_US     15
`define FCS_ABORT_TIME_US    25
`define FCS_WIN_CYC          ((`FCS_WIN_TIME_US * 1000) / `FCS_CLK_PERIOD_NS)
`define FCS_SUSP_CYC         ((`FCS_SUSP_TIME_US * 1000) / `FCS_CLK_PERIOD_NS)
`define FCS_ABORT_CYC        ((`FCS_ABORT_TIME_US * 1000) / `FCS_CLK_PERIOD_NS)

`endif

// File: hw/fcs_pkg.sv
/*
  Types of the flash command sequencer: sequencer states and core operations.
  Assumes nothing of its surroundings.
*/
package fcs_pkg;

  // ==========================================================
  // sequencer states
  typedef enum logic [4:0] {
    ST_READ  = 5'h00,
    ST_UNL1  = 5'h01,
    ST_UNL2  = 5'h02,
    ST_PSET  = 5'h03,
    ST_PROG  = 5'h04,
    ST_BYP   = 5'h05,
    ST_BYPX  = 5'h06,
    ST_ERS0  = 5'h07,
    ST_ERS1  = 5'h08,
    ST_ERS2  = 5'h09,
    ST_BULK  = 5'h0A,
    ST_SWIN  = 5'h0B,
    ST_SECT  = 5'h0C,
    ST_SWAIT = 5'h0D,
    ST_SUSP  = 5'h0E,
    ST_ABORT = 5'h0F,
    ST_ERR   = 5'h10
  } fcs_state_t;

  // ==========================================================
  // operation handed to the cell core
  typedef enum logic [1:0] {
    OP_NONE   = 2'h0,
    OP_PROG   = 2'h1,
    OP_BULK   = 2'h2,
    OP_SECTOR = 2'h3
  } fcs_op_t;

endpackage : fcs_pkg

// File: tb/fcs_core_model.sv
/*
  cell core stand-in: one done pulse DLY unheld cycles after each start, none if aborted first.
  assumes start, abort and suspend come from the sequencer on i_sys_clk.
*/
`timescale 1ns/1ps
module fcs_core_model #(
  parameter int DLY = 40
) (
  input  wire logic i_sys_clk,
  input  wire logic i_srst,
  input  wire logic i_start,
  input  wire logic i_abort,
  input  wire logic i_hold,
  input  wire logic i_fail,
  output logic      o_done,
  output logic      o_fail
);
  // ==========================================================
  // busy counter
  int cnt_q;
  always_ff @(posedge i_sys_clk) begin
    o_done <= 1'b0;
    if (i_srst || i_abort) cnt_q <= 0;
    else if (i_start) cnt_q <= DLY;
    // a suspended erase makes no progress
    else if (cnt_q > 0 && !i_hold) begin
      cnt_q  <= cnt_q - 1;
      o_done <= (cnt_q == 1);
    end
  end
  assign o_fail = o_done & i_fail;
endmodule : fcs_core_model

// File: tb/flash_command_sequencer_test.sv
/*
  self-checking bench of the flash command sequencer with a core model.
  assumes shortened window, suspend and abort counts set below.
*/
`timescale 1ns/1ps
module flash_command_sequencer_test;
  localparam int          WIN = 20, SUS = 5, ABT = 8, DLY = 40;
  localparam logic [15:0] U1  = 16'h0555, U2 = 16'h0AAA;
  logic             clk = 1'b0, srst = 1'b1, mrst = 1'b0, bwr = 1'b0, brd = 1'b0, fail = 1'b0;
  logic [15:0]      addr = 16'h0000, caddr;
  logic [7:0]       wd = 8'h00, ard = 8'h00, rdat, cdat, d;
  logic [11:0]      sel = 12'h001, prot = 12'h000, cmask;
  logic             rv, inv, start, susp, abort, rdy, byp, done, cfail;
  fcs_pkg::fcs_op_t op;
  logic [16:0]      rq[$];
  logic [29:0]      sq[$];
  int               n_mismatch = 0, n_compared = 0;

  initial forever #2.5 clk = ~clk;

  fcs_flash_command_sequencer #(.WIN_CYC(WIN), .SUSP_CYC(SUS), .ABORT_CYC(ABT)) u_dut (
    .i_sys_clk(clk), .i_srst(srst), .i_mod_reset(mrst), .i_bus_wr(bwr), .i_bus_rd(brd),
    .i_bus_addr(addr), .i_bus_wdata(wd), .i_sector_sel(sel), .i_sector_prot(prot),
    .i_array_rdata(ard), .i_core_done(done), .i_core_fail(cfail), .o_bus_rdata(rdat),
    .o_bus_rvalid(rv), .o_rd_invalid(inv), .o_core_start(start), .o_core_op(op),
    .o_core_addr(caddr), .o_core_data(cdat), .o_core_mask(cmask), .o_core_suspend(susp),
    .o_core_abort(abort), .o_ready(rdy), .o_bypass(byp));
  fcs_core_model #(.DLY(DLY)) u_core (.i_sys_clk(clk), .i_srst(srst), .i_start(start),
    .i_abort(abort), .i_hold(susp), .i_fail(fail), .o_done(done), .o_fail(cfail));

  // ==========================================================
  // checking
  task automatic miss(input string m);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : miss
  task automatic cmp_lvl(input logic g, input logic e);
    n_compared++;
    if (g !== e) miss("level");
  endtask : cmp_lvl
  task automatic cmp_rd(input logic [16:0] e);
    n_compared++;
    if (((rdat ^ e[7:0]) & e[15:8]) !== 8'h00 || inv !== e[16]) miss("read data");
  endtask : cmp_rd
  task automatic cmp_st(input logic [29:0] e);
    n_compared++;
    if (op !== e[13:12] || ((op == fcs_pkg::OP_PROG) ? {4'h0, cdat} : cmask) !== e[11:0] ||
        caddr !== e[29:14]) miss("core start");
  endtask : cmp_st
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      if (rq.size() == 0) miss("stray read");
      else cmp_rd(rq.pop_front());
    end
    if (start === 1'b1) begin
      if (sq.size() == 0) miss("stray start");
      else cmp_st(sq.pop_front());
    end
  end

  // ==========================================================
  // host cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] v, input int s);
    @(negedge clk);
    bwr = 1'b1; addr = a; wd = v; sel = 12'h001 << s;
    @(negedge clk);
    bwr = 1'b0;
  endtask : wr
  // a zero mask expects plain array data
  task automatic rd(input int s, input logic [7:0] m, input logic [7:0] v, input logic i);
    @(negedge clk);
    brd = 1'b1; sel = 12'h001 << s; ard = 8'($urandom);
    rq.push_back((m == 8'h00) ? {1'b0, 8'hFF, ard} : {i, m, v});
    @(negedge clk);
    brd = 1'b0;
  endtask : rd
  task automatic wt(input logic e, input int lim);
    for (int k = 0; k < lim && rdy !== e; k++) @(negedge clk);
    if (rdy !== e) begin
      miss("wait ran out");
      test_done();
    end
  endtask : wt
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask : settle
  task automatic unl(input int s);
    wr(U1, 8'hAA, s);
    wr(U2, 8'h55, s);
  endtask : unl
  task automatic ers(input logic [7:0] c, input int s);
    unl(s); wr(U1, 8'h80, s); unl(s); wr(U1, c, s);
  endtask : ers

  // ==========================================================
  // scenarios
  initial begin
    d = 8'($urandom(11));
    repeat (12) @(negedge clk);
    srst = 1'b0;
    unl(0); wr(U1, 8'h20, 0); settle(); cmp_lvl(byp, 1'b1);
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      wr(16'h1000, 8'hA0, 1);
      sq.push_back({16'h1234, fcs_pkg::OP_PROG, 4'h0, d});
      wr(16'h1234, d, 1);
      wt(1'b0, 5); rd(1, 8'h80, ~d, 1'b0); wt(1'b1, DLY + 10);
    end
    prot = 12'h008; wr(16'h1000, 8'hA0, 3); wr(16'h3000, d, 3); settle(); cmp_lvl(rdy, 1'b1);
    rd(3, 8'h00, 8'h00, 1'b0); prot = 12'h000;
    wr(U1, 8'h80, 0); wr(U1, 8'h10, 0); settle(); cmp_lvl(rdy, 1'b1);
    wr(U1, 8'h90, 2); wr(U2, 8'h00, 2); settle(); cmp_lvl(byp, 1'b0);
    unl(4); wr(U1, 8'h80, 4); wr(U1, 8'hAA, 4); wr(U2, 8'h54, 4); wr(U1, 8'h10, 4);
    settle(); cmp_lvl(rdy, 1'b1); rd(4, 8'h00, 8'h00, 1'b0);
    sq.push_back({U1, fcs_pkg::OP_BULK, 12'hFFF}); ers(8'h10, 9); wt(1'b0, 5);
    wr(U1, 8'hF0, 9); rd(9, 8'hA0, 8'h00, 1'b0); settle(); cmp_lvl(rdy, 1'b0);
    wt(1'b1, DLY + 10);
    fail = 1'b1; sq.push_back({U1, fcs_pkg::OP_BULK, 12'hFFF}); ers(8'h10, 10);
    repeat (DLY + 8) @(negedge clk);
    rd(10, 8'h20, 8'h20, 1'b0); fail = 1'b0; wr(U1, 8'hF0, 10);
    wt(1'b1, ABT + 5); rd(10, 8'h00, 8'h00, 1'b0);
    ers(8'h30, 2); repeat (5) @(negedge clk); wr(U1, 8'h30, 5);
    rd(5, 8'h88, 8'h00, 1'b0); sq.push_back({U1, fcs_pkg::OP_SECTOR, 12'h024});
    repeat (WIN + 4) @(negedge clk); rd(5, 8'h88, 8'h08, 1'b0);
    wr(U1, 8'hA0, 5); wr(U1, 8'hB0, 5); repeat (SUS + 4) @(negedge clk);
    cmp_lvl(susp, 1'b1);
    rd(2, 8'hFF, 8'hFF, 1'b1); rd(7, 8'h00, 8'h00, 1'b0);
    wr(16'h7000, 8'hA0, 7); wr(16'h7001, 8'h00, 7); wr(U1, 8'h30, 7);
    cmp_lvl(susp, 1'b0);
    wr(U1, 8'hF0, 7); cmp_lvl(abort, 1'b1);
    wt(1'b1, ABT + 5);
    sq.push_back({U1, fcs_pkg::OP_BULK, 12'hFFF}); ers(8'h10, 0); wt(1'b0, 5);
    mrst = 1'b1; settle(); cmp_lvl(abort, 1'b1);
    mrst = 1'b0; wt(1'b1, ABT + 6);
    // an expected result that never showed up is a miss too
    if (rq.size() != 0 || sq.size() != 0) miss("result never seen");
    test_done();
  end
endmodule : flash_command_sequencer_test
